// ==== include/sqd_pkg.sv ====
// constants shared by the squib command decoder
// assumes a 100 MHz core clock and 16-bit command frames
package sqd_pkg;
    // frame and field layout
    localparam int FRAME_BITS = 16;
    localparam int PAR_BIT = 13;
    localparam int RW_BIT = 12;
    localparam int SWR_BIT = 11;
    localparam int SUB_BIT = 10;
    // command classes in the top two bits
    localparam logic [1:0] CLS_CFG = 2'h0;
    localparam logic [1:0] CLS_DEP = 2'h1;
    localparam logic [1:0] CLS_DIAG = 2'h2;
    localparam logic [1:0] CLS_MON = 2'h3;
    // deployment sub-codes on bits 12..8
    localparam logic [4:0] DEP_ARM = 5'h19;
    localparam logic [4:0] DEP_FIRE = 5'h00;
    // diagnostic sub-codes on bits 11..9
    localparam logic [2:0] DG_OFF = 3'h0;
    localparam logic [2:0] DG_SHORT = 3'h1;
    localparam logic [2:0] DG_RESV = 3'h2;
    localparam logic [2:0] DG_SAFING = 3'h3;
    localparam logic [2:0] DG_RES = 3'h4;
    localparam logic [2:0] DG_HIRES = 3'h5;
    localparam logic [2:0] DG_LSD = 3'h6;
    localparam logic [2:0] DG_HSD = 3'h7;
    // soft reset patterns
    localparam logic [7:0] SR_FIRST = 8'hAA;
    localparam logic [7:0] SR_SECOND = 8'h55;
    // fixed response words
    localparam logic [15:0] RSP_ZERO = 16'h0000;
    localparam logic [15:0] RSP_PARITY = 16'hD000;
    localparam logic [15:0] RSP_LENGTH = 16'hD003;
    localparam logic [15:0] RSP_NOARM = 16'hD005;
    localparam logic [15:0] RSP_BUSY = 16'hD009;
    localparam logic [15:0] RSP_SRDONE = 16'h2003;
    localparam logic [3:0] RSP_SR1_TOP = 4'h1;
    localparam logic [1:0] RSP_SR1_X = 2'h2;
    localparam logic [7:0] RSP_SR1_LOW = 8'h02;
    localparam logic [7:0] RSP_CFG1_LOW = 8'h02;
    // reset values
    localparam logic [1:0] CL_RESET = 2'h0;
    localparam logic [1:0] FEN_RESET = 2'h0;
    // deployment hold time
    localparam int CLK_MHZ = 100;
    localparam int DEPLOY_TIME_US = 2000;
    localparam int DEPLOY_CYCLES = DEPLOY_TIME_US * CLK_MHZ;
    // revision byte, value arbitrary
    localparam logic [7:0] REV_ID = 8'h11;
endpackage

// ==== core/sqd_sync.sv ====
// two-flop synchroniser bank for pins entering the core clock
// assumes nrst is the core asynchronous reset
`timescale 1ns/1ps
module sqd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins in, synced out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // one pair of flops per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                meta[i] <= INIT[i];
                dout[i] <= INIT[i];
            end else begin
                meta[i] <= din[i];
                dout[i] <= meta[i];
            end
        end
    end
endmodule

// ==== core/sqd_decoder.sv ====
// squib serial port command decoder and response builder
// assumes spi mode 0 pins sampled by clk, all pins asynchronous
// Notes on behaviour
// - safing code: 00 below short, 01 between, 11 above open threshold
// - safing and reserve comparators sampled at next chip-select fall
// - reserve voltage code: 00 below low, 01 between, 11 above high
// - lost ground blocks low side drive; high side still driven
// - lost ground on one channel leaves all other channels alone
// - lost ground shows in the low-side driver diagnostic and in monitor reply 1
// - every word except the zero word and 1X02 carries odd parity in bit 13
// - response goes out in the frame after the command
// - reset, reset release, ground loss, bad reference: next word zero
// - parity error answered with D000 next frame
// - wrong clock count answered with D003 next frame
// - fire only after valid arm; otherwise D005
// - command not allowed while deploying answered with D009
// - first pattern answers 1X02 with stored limit; second answers 2003
// - top two bits select configuration, deployment, diagnostic, monitor
// - configuration bit 10 picks current limit/soft reset or latch time
// - diagnostic bits 11..9 pick one of eight diagnostics
// - monitor bits 11..10 pick one of four status replies
// - parity fault describes the frame just before it
// - completed soft reset resets squib and satellite circuits
// - soft reset needs AA then 55 in consecutive frames
// - latched diagnostic results hold until next diagnostic write or soft reset
`timescale 1ns/1ps
module sqd_decoder #(
    parameter int CHANNELS = 8,
    parameter int DEPLOY_CYCLES = sqd_pkg::DEPLOY_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // squib serial port pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    // comparator and fault inputs
    input wire logic safingAboveShort,
    input wire logic safingAboveOpen,
    input wire logic reserveAboveLow,
    input wire logic reserveAboveHigh,
    input wire logic [CHANNELS-1:0] channelGroundLost,
    input wire logic externalResetN,
    input wire logic referenceResistorBad,
    // control outputs
    output logic softResetPulse,
    output logic [1:0] currentLimitSelect,
    output logic [1:0] fenLatchTime,
    output logic armed,
    output logic deployActive,
    output logic [CHANNELS-1:0] highSideDrive,
    output logic [CHANNELS-1:0] lowSideDrive,
    // diagnostic control and results
    output logic diagStart,
    output logic [2:0] diagMode,
    output logic [2:0] diagChannel,
    output logic [1:0] diagResult
);
    localparam int NS = 9 + CHANNELS;
    localparam int DW = $clog2(DEPLOY_CYCLES + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } sqd_frame_e;

    typedef struct packed {
        sqd_frame_e frame;
        logic prevSclk;
        logic prevCs;
        logic [4:0] bitCount;
        logic [15:0] rxShift;
        logic [15:0] txShift;
        logic miso;
        logic [15:0] respWord;
        logic respCode;
        logic respSample;
        logic zeroPending;
        logic [CHANNELS-1:0] groundSeen;
        logic extSeen;
        logic rrefSeen;
        logic aaSeen;
        logic armed;
        logic [1:0] currentLimit;
        logic [1:0] fenLatch;
        logic [DW-1:0] deployCount;
        logic deployOn;
        logic [CHANNELS-1:0] highSide;
        logic [CHANNELS-1:0] lowSide;
        logic softReset;
        logic diagStart;
        logic [2:0] diagMode;
        logic [2:0] diagChannel;
        logic [1:0] diagResult;
    } sqd_state_s;

    sqd_state_s s;
    sqd_state_s next_s;
    logic [NS-1:0] syncOut;
    logic zeroEvent;
    logic sclkS, csS, mosiS, extS, rrefS;
    logic safShortS, safOpenS, resLoS, resHiS;
    logic [CHANNELS-1:0] groundS;
    logic csFall, csRise, sclkRise, sclkFall;
    logic [15:0] cmd;
    logic [15:0] loadWord;
    logic [1:0] liveResult;
    logic goodFrame;

    // every pin passes two flops; idle-high pins (reset release, select) reset high
    sqd_sync #(
        .W(NS),
        .INIT({{CHANNELS{1'b0}}, 9'h084})
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({channelGroundLost, referenceResistorBad, externalResetN,
              reserveAboveHigh, reserveAboveLow, safingAboveOpen,
              safingAboveShort, csN, sclk, mosi}),
        .dout(syncOut)
    );
    assign {groundS, rrefS, extS, resHiS, resLoS, safOpenS, safShortS, csS, sclkS, mosiS} =
        syncOut;

    // edges of the synced link signals
    assign csFall = s.prevCs && !csS;
    assign csRise = !s.prevCs && csS;
    assign sclkRise = !s.prevSclk && sclkS;
    assign sclkFall = s.prevSclk && !sclkS;
    assign cmd = s.rxShift;
    assign goodFrame = (s.bitCount == 5'(sqd_pkg::FRAME_BITS)) && (^cmd);
    // reset-like events: ground loss, reset release, bad reference
    assign zeroEvent = (|(groundS & ~s.groundSeen)) || (extS && !s.extSeen) ||
                       (rrefS && !s.rrefSeen);

    // live comparator code for the pending diagnostic
    always_comb begin
        case (s.diagMode)
            sqd_pkg::DG_SAFING: liveResult = {safOpenS, safOpenS | safShortS};
            sqd_pkg::DG_RESV: liveResult = {resHiS, resHiS | resLoS};
            sqd_pkg::DG_LSD: liveResult = {1'b0, groundS[s.diagChannel]};
            default: liveResult = 2'h0;
        endcase
    end

    // word loaded at the start of a frame
    always_comb begin
        loadWord = s.respWord;
        if (s.respSample) begin
            loadWord[1:0] = liveResult;
        end
        if (!s.respCode) begin
            loadWord[sqd_pkg::PAR_BIT] = ~^{loadWord[15:14], loadWord[12:0]};
        end
        if (s.zeroPending) begin
            loadWord = sqd_pkg::RSP_ZERO;
        end
    end

    // next state of the whole block
    always_comb begin
        next_s = s;
        next_s.prevSclk = sclkS;
        next_s.prevCs = csS;
        next_s.softReset = 1'b0;
        next_s.diagStart = 1'b0;
        // reset-like events force a zero word
        next_s.groundSeen = groundS;
        next_s.extSeen = extS;
        next_s.rrefSeen = rrefS;
        // deployment timer; per channel low side dropped on lost ground
        if (s.deployCount != '0) begin
            next_s.deployCount = s.deployCount - DW'(1);
        end else begin
            next_s.highSide = '0;
            next_s.lowSide = '0;
        end
        next_s.lowSide = next_s.lowSide & ~groundS;
        case (s.frame)
            ST_IDLE: begin
                if (csFall) begin
                    next_s.frame = ST_FRAME;
                    next_s.bitCount = 5'h00;
                    next_s.txShift = loadWord;
                    next_s.miso = loadWord[15];
                    next_s.zeroPending = 1'b0;
                    if (s.respSample) begin
                        next_s.diagResult = liveResult;
                        next_s.respSample = 1'b0;
                    end
                end
            end
            ST_FRAME: begin
                if (sclkRise) begin
                    next_s.rxShift = {s.rxShift[14:0], mosiS};
                    if (s.bitCount != 5'h1F) begin
                        next_s.bitCount = s.bitCount + 5'h01;
                    end
                end
                if (sclkFall) begin
                    next_s.txShift = {s.txShift[14:0], 1'b0};
                    next_s.miso = s.txShift[14];
                end
                if (csRise) begin
                    next_s.frame = ST_IDLE;
                    next_s.aaSeen = 1'b0;
                    next_s.respCode = 1'b0;
                    next_s.respWord = {cmd[15:8], 8'h00};
                    if (s.bitCount != 5'(sqd_pkg::FRAME_BITS)) begin
                        next_s.respWord = sqd_pkg::RSP_LENGTH;
                        next_s.respCode = 1'b1;
                    end else if (!(^cmd)) begin
                        next_s.respWord = sqd_pkg::RSP_PARITY;
                        next_s.respCode = 1'b1;
                    end else if ((s.deployCount != '0) &&
                                 (cmd[15:14] == sqd_pkg::CLS_CFG ||
                                  cmd[15:14] == sqd_pkg::CLS_DIAG)) begin
                        next_s.respWord = sqd_pkg::RSP_BUSY;
                        next_s.respCode = 1'b1;
                    end else begin
                        case (cmd[15:14])
                            sqd_pkg::CLS_CFG: begin
                                if (!cmd[sqd_pkg::SUB_BIT]) begin
                                    if (cmd[sqd_pkg::RW_BIT] && cmd[sqd_pkg::SWR_BIT] &&
                                        cmd[7:0] == sqd_pkg::SR_FIRST) begin
                                        next_s.aaSeen = 1'b1;
                                        next_s.respWord = {sqd_pkg::RSP_SR1_TOP,
                                            sqd_pkg::RSP_SR1_X, s.currentLimit,
                                            sqd_pkg::RSP_SR1_LOW};
                                        next_s.respCode = 1'b1;
                                    end else if (cmd[sqd_pkg::RW_BIT] && cmd[sqd_pkg::SWR_BIT] &&
                                                 cmd[7:0] == sqd_pkg::SR_SECOND && s.aaSeen) begin
                                        next_s.respWord = sqd_pkg::RSP_SRDONE;
                                        next_s.respCode = 1'b1;
                                        next_s.softReset = 1'b1;
                                        next_s.currentLimit = sqd_pkg::CL_RESET;
                                        next_s.fenLatch = sqd_pkg::FEN_RESET;
                                        next_s.armed = 1'b0;
                                        next_s.deployCount = '0;
                                        next_s.highSide = '0;
                                        next_s.lowSide = '0;
                                        next_s.diagResult = 2'h0;
                                        next_s.respSample = 1'b0;
                                    end else begin
                                        if (cmd[sqd_pkg::RW_BIT] && !cmd[sqd_pkg::SWR_BIT]) begin
                                            next_s.currentLimit = cmd[9:8];
                                        end
                                        next_s.respWord = {3'h0, cmd[12:11], 1'b0,
                                            next_s.currentLimit, sqd_pkg::RSP_CFG1_LOW};
                                    end
                                end else begin
                                    if (cmd[sqd_pkg::RW_BIT]) begin
                                        next_s.fenLatch = cmd[9:8];
                                    end
                                    next_s.respWord = {3'h0, cmd[12], 2'h1,
                                        next_s.fenLatch, 8'h00};
                                end
                            end
                            sqd_pkg::CLS_DEP: begin
                                if (cmd[12:8] == sqd_pkg::DEP_ARM) begin
                                    next_s.armed = 1'b1;
                                end else if (cmd[12:8] == sqd_pkg::DEP_FIRE) begin
                                    if (s.armed) begin
                                        next_s.armed = 1'b0;
                                        next_s.highSide = cmd[CHANNELS-1:0];
                                        next_s.lowSide = cmd[CHANNELS-1:0] & ~groundS;
                                        next_s.deployCount = DW'(DEPLOY_CYCLES);
                                        next_s.respWord = cmd;
                                    end else begin
                                        next_s.respWord = sqd_pkg::RSP_NOARM;
                                        next_s.respCode = 1'b1;
                                    end
                                end else begin
                                    next_s.armed = 1'b0;
                                end
                            end
                            sqd_pkg::CLS_DIAG: begin
                                if (cmd[sqd_pkg::RW_BIT]) begin
                                    next_s.diagMode = cmd[11:9];
                                    next_s.diagChannel = cmd[2:0];
                                    next_s.diagStart = 1'b1;
                                    next_s.respSample = 1'b1;
                                end else begin
                                    next_s.respWord[1:0] = s.diagResult;
                                end
                            end
                            sqd_pkg::CLS_MON: begin
                                case (cmd[11:10])
                                    2'h0: next_s.respWord[7:0] = {6'h00,
                                        s.deployCount != '0, s.armed};
                                    2'h1: next_s.respWord[7:0] = 8'(groundS);
                                    2'h2: next_s.respWord[7:0] = {4'h0, s.fenLatch,
                                        s.currentLimit};
                                    default: next_s.respWord[7:0] = sqd_pkg::REV_ID;
                                endcase
                            end
                            default: next_s.respWord = cmd;
                        endcase
                    end
                end
            end
            default: next_s.frame = ST_IDLE;
        endcase
        // event wins over the clear at a frame start
        if (zeroEvent) begin
            next_s.zeroPending = 1'b1;
        end
        next_s.deployOn = next_s.deployCount != '0;
    end

    // the single state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.frame <= ST_IDLE;
            s.prevCs <= 1'b1;
            s.prevSclk <= 1'b0;
            s.extSeen <= 1'b1;
            s.respCode <= 1'b1;
            s.currentLimit <= sqd_pkg::CL_RESET;
            s.fenLatch <= sqd_pkg::FEN_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign miso = s.miso;
    assign softResetPulse = s.softReset;
    assign currentLimitSelect = s.currentLimit;
    assign fenLatchTime = s.fenLatch;
    assign armed = s.armed;
    assign deployActive = s.deployOn;
    assign highSideDrive = s.highSide;
    assign lowSideDrive = s.lowSide;
    assign diagStart = s.diagStart;
    assign diagMode = s.diagMode;
    assign diagChannel = s.diagChannel;
    assign diagResult = s.diagResult;

    // checks on the decoder
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_length;
        s.frame == ST_FRAME && csRise && s.bitCount != 5'd16 |=>
            s.respWord == sqd_pkg::RSP_LENGTH && $stable(s.currentLimit);
    endproperty
    a_length: assert property (p_length) else $error("bad count not D003");

    property p_parity_err;
        s.frame == ST_FRAME && csRise && s.bitCount == 5'd16 && !(^cmd) |=>
            s.respWord == sqd_pkg::RSP_PARITY ##1 $stable(s.fenLatch);
    endproperty
    a_parity_err: assert property (p_parity_err) else $error("parity fault not D000");

    property p_odd_out;
        s.frame == ST_IDLE && csFall && !s.respCode && !s.zeroPending |=> ^s.txShift;
    endproperty
    a_odd_out: assert property (p_odd_out) else $error("response parity even");

    property p_zero;
        s.frame == ST_IDLE && csFall && s.zeroPending |=> s.txShift == 16'h0000 && s.miso == 1'b0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero word not sent");

    property p_noarm;
        s.frame == ST_FRAME && csRise && goodFrame && s.deployCount == '0 &&
            cmd[15:14] == sqd_pkg::CLS_DEP && cmd[12:8] == sqd_pkg::DEP_FIRE && !s.armed |=>
            s.respWord == sqd_pkg::RSP_NOARM && s.highSide == '0;
    endproperty
    a_noarm: assert property (p_noarm) else $error("fire without arm accepted");

    property p_ground;
        ##1 (lowSideDrive & $past(groundS)) == '0;
    endproperty
    a_ground: assert property (p_ground) else $error("low side on lost ground");

    property p_busy;
        s.frame == ST_FRAME && csRise && goodFrame && s.deployCount > DW'(1) &&
            cmd[15:14] == sqd_pkg::CLS_DIAG |=> s.respWord == sqd_pkg::RSP_BUSY && !diagStart;
    endproperty
    a_busy: assert property (p_busy) else $error("diag taken while deploying");

    property p_softreset;
        softResetPulse |-> s.respWord == sqd_pkg::RSP_SRDONE && $past(s.aaSeen) &&
            s.currentLimit == sqd_pkg::CL_RESET;
    endproperty
    a_softreset: assert property (p_softreset) else $error("soft reset out of sequence");

    property p_hold;
        !$past(s.respSample && csFall && s.frame == ST_IDLE) && !$past(s.softReset) &&
            !$past(next_s.softReset) |-> $stable(diagResult);
    endproperty
    a_hold: assert property (p_hold) else $error("diag result moved");

    c_fire: cover property (s.armed ##[1:1000] deployActive);
    c_softreset: cover property (softResetPulse);
    c_sample: cover property (s.respSample ##[1:1000] !s.respSample);
endmodule

// ==== testbench/sqd_spi_host.sv ====
// spi host model driving the squib serial port in mode 0
// assumes clk is the 100 MHz core clock; sclk runs at 80 ns in frames
`timescale 1ns/1ps
module sqd_spi_host (
    // pacing clock
    input wire logic clk,
    // serial pins toward the decoder
    output logic sclk,
    output logic csN,
    output logic mosi,
    input wire logic miso
);
    // idle pins: clock parked low, select high
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end

    // one frame of n bits, msb first, word already carries its parity
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk) csN <= 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi <= w[15 - i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            if (i < 16) r[15 - i] = miso;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        csN <= 1'b1;
        mosi <= ~mosi; // released line shows no stale bit
        repeat (8) @(posedge clk);
    endtask
endmodule

// ==== testbench/sqd_decoder_tb.sv ====
// self-checking bench for the squib command decoder
// assumes the host model owns the serial pins
`timescale 1ns/1ps
module sqd_decoder_tb;
    logic clk, nrst, safeShort, safeOpen, resLow, resHigh, extResetN, refBad;
    logic sclk, csN, mosi, miso, softResetPulse, deployActive, armedOut, diagStartOut;
    logic [7:0] gndLost, hsDrive, lsDrive;
    logic [1:0] curLimit, diagResult, fenLatch;
    logic [2:0] diagModeOut, diagChan;
    logic [15:0] rsp;
    int num_errors = 0, total_checks = 0, pulses = 0, diagPulses = 0;

    sqd_decoder #(.CHANNELS(8), .DEPLOY_CYCLES(2000)) u_sqd_decoder (
        .clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
        .safingAboveShort(safeShort), .safingAboveOpen(safeOpen),
        .reserveAboveLow(resLow), .reserveAboveHigh(resHigh),
        .channelGroundLost(gndLost), .externalResetN(extResetN),
        .referenceResistorBad(refBad), .softResetPulse(softResetPulse),
        .currentLimitSelect(curLimit), .fenLatchTime(fenLatch), .armed(armedOut),
        .deployActive(deployActive), .highSideDrive(hsDrive), .lowSideDrive(lsDrive),
        .diagStart(diagStartOut), .diagMode(diagModeOut), .diagChannel(diagChan),
        .diagResult(diagResult)
    );
    sqd_spi_host u_sqd_spi_host (
        .clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso)
    );

    // clock and soft reset pulse count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (softResetPulse === 1'b1) pulses <= pulses + 1;
    always @(posedge clk) if (diagStartOut === 1'b1) diagPulses <= diagPulses + 1;

    // odd parity in bit 13
    function automatic logic [15:0] par(input logic [15:0] w);
        par = w;
        par[13] = ~^w;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic tx(input logic [15:0] w, input logic [15:0] want, input bit chk);
        u_sqd_spi_host.xfer(w, 16, rsp);
        if (chk) check(rsp, want);
    endtask

    // diag write, comparators set, result frame, then hold check
    task automatic diag(input logic [15:0] cmd, input logic [1:0] lvl, input logic [1:0] code);
        tx(par(cmd), 16'h0000, 0);
        check({13'h0, diagModeOut}, {13'h0, cmd[11:9]});
        check({13'h0, diagChan}, {13'h0, cmd[2:0]});
        {safeOpen, safeShort} <= lvl;
        {resHigh, resLow} <= lvl;
        repeat (6) @(posedge clk);
        tx(par(16'h0000), 16'h0000, 0);
        check({14'h0, rsp[1:0]}, {14'h0, code});
        check({14'h0, diagResult}, {14'h0, code});
        {safeOpen, safeShort} <= ~lvl;
        {resHigh, resLow} <= ~lvl;
        tx(par(16'h0000), 16'h0000, 0);
        check({14'h0, diagResult}, {14'h0, code});
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    // main sequence
    initial begin
        {nrst, safeShort, safeOpen, resLow, resHigh, refBad} = 6'h00;
        extResetN = 1'b1;
        gndLost = 8'h00;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        tx(par(16'h0000), sqd_pkg::RSP_ZERO, 1);
        tx(par(16'h0000), par(16'h0002), 1);
        tx(16'h0000, 16'h0000, 0);
        tx(par(16'h1300), sqd_pkg::RSP_PARITY, 1);
        tx(16'h1100, 16'h0000, 0);
        check({14'h0, curLimit}, 16'h0003);
        u_sqd_spi_host.xfer(par(16'h0000), 15, rsp);
        tx(par(16'h0000), sqd_pkg::RSP_LENGTH, 1);
        tx(par(16'h4001), par(16'h0302), 1);
        tx(par(16'h0000), sqd_pkg::RSP_NOARM, 1);
        tx(par(16'h1500), 16'h0000, 0);
        check({14'h0, fenLatch}, 16'h0001);
        // broken soft reset, then a complete one
        tx(par(16'h18AA), par(16'h1500), 1);
        tx(par(16'h0000), 16'h1B02, 1);
        tx(par(16'h1855), 16'h0000, 0);
        tx(par(16'h0000), 16'h0000, 0);
        check(16'(pulses), 16'h0000);
        tx(par(16'h18AA), 16'h0000, 0);
        tx(par(16'h1855), 16'h1B02, 1);
        tx(par(16'h0000), sqd_pkg::RSP_SRDONE, 1);
        check(16'(pulses), 16'h0001);
        check({14'h0, curLimit}, 16'h0000);
        check({14'h0, fenLatch}, 16'h0000);
        // ground loss on channel 1, then arm and fire channels 0 and 1
        gndLost <= 8'h02;
        repeat (6) @(posedge clk);
        tx(par(16'h0000), sqd_pkg::RSP_ZERO, 1);
        tx(par(16'h5900), 16'h0000, 0);
        check({15'h0, armedOut}, 16'h0001);
        tx(par(16'h4003), par(16'h5900), 1);
        check({8'h0, hsDrive}, 16'h0003);
        check({8'h0, lsDrive}, 16'h0001);
        check({15'h0, deployActive}, 16'h0001);
        check({15'h0, armedOut}, 16'h0000);
        tx(par(16'h0000), par(16'h4003), 1);
        tx(par(16'h9600), sqd_pkg::RSP_BUSY, 1);
        tx(par(16'h0000), sqd_pkg::RSP_BUSY, 1);
        check(16'(diagPulses), 16'h0000);
        repeat (2000) @(posedge clk);
        // reset release and bad reference events
        extResetN <= 1'b0;
        repeat (4) @(posedge clk);
        extResetN <= 1'b1;
        repeat (6) @(posedge clk);
        tx(par(16'h0000), sqd_pkg::RSP_ZERO, 1);
        refBad <= 1'b1;
        repeat (6) @(posedge clk);
        tx(par(16'h0000), sqd_pkg::RSP_ZERO, 1);
        // all diagnostic modes on channel 1, then threshold levels
        for (int m = 0; m < 8; m++)
            diag({4'h9, m[2:0], 9'h001}, 2'h3, (m == 2 || m == 3) ? 2'h3 : (m == 6) ? 2'h1 : 2'h0);
        for (int l = 0; l < 2; l++) begin
            diag(16'h9600, l[1:0], l[1:0]);
            diag(16'h9400, l[1:0], l[1:0]);
        end
        check(16'(diagPulses), 16'h000C);
        wrap_up();
    end
endmodule
